// ### include/omc_params.svh
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

// ========================================
// register byte addresses
`define OMC_ADDR_MODE 12'h000
`define OMC_ADDR_POLARITY 12'h004
`define OMC_ADDR_IOSEL 12'h008
`define OMC_ADDR_STATUS 12'h00C

// ========================================
// field positions
`define OMC_SYNC_BIT 0
`define OMC_ARCH_BIT 1
`define OMC_STATUS_VALID_BIT 0
`define OMC_STATUS_MODE_LSB 1
`define OMC_STATUS_CELLREG_LSB 8

// ========================================
// reset values
`define OMC_SYNC_RESET 1'h0
`define OMC_ARCH_RESET 1'h0
`define OMC_POLARITY_RESET 8'h00
`define OMC_IOSEL_RESET 8'h00
`define OMC_CELLREG_RESET 8'h00

// ========================================
// cell geometry
`define OMC_CELLS 8
`define OMC_TERMS 8
`define OMC_OUTER_LOW 0
`define OMC_OUTER_HIGH 7
`define OMC_CENTRE_LOW 3
`define OMC_CENTRE_HIGH 4

`endif

// ### include/omc_pkg.sv
package omc_pkg;

    // ========================================
    // global configuration modes
    typedef enum logic [1:0] {
        OMC_REGISTERED,
        OMC_COMPLEX,
        OMC_SIMPLE,
        OMC_INVALID
    } omc_mode_type;

    // ========================================
    // apb carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } omc_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } omc_apb_rsp_type;

    // ========================================
    // pin and array carriers
    typedef logic [7:0][7:0] omc_terms_type;

    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOutEnN;
        logic [7:0] feedback;
    } omc_cell_out_type;

    // ========================================
    // complete block state
    typedef struct packed {
        logic syncModeSelect;
        logic globalArchCtl;
        logic [7:0] polaritySelect;
        logic [7:0] cellIoSelect;
        logic [7:0] cellReg;
        logic clkPinPrev;
        omc_cell_out_type cells;
        omc_apb_rsp_type rsp;
    } omc_state_type;

endpackage

// ### src/omc_output_macrocell.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "omc_params.svh"

// How it works
// RL1: three global modes, registered, complex, simple, chosen for all cells by two bits.
// RL2: configuration is two global bits plus sixteen per-cell bits, two per cell.
// RL3: each cell's polarity bit sets its output polarity in every mode.
// RL4: each cell's io select bit chooses its input/output use within the active mode.
// RL5: polarity zero gives an active-low output, one an active-high output.
// RL6: registered mode fixes clock pin and enable pin; neither feeds the array.
// RL7: all registered cells share the one clock pin and one enable pin.
// RL8: registered mode: each cell registered output or io, up to eight of either.
// RL9: registered mode: dedicated input or output is a restricted io cell.
// RL10: registered output sums eight terms; io cell sums seven.
// RL11: complex mode: clock and enable pins borrow outer cells' feedback slots.
// RL12: complex mode: six inner cells are io, two outer cells output only.
// RL13: complex mode: outer cells give no input path into the array.
// RL14: complex mode: seven terms for the sum, one term drives output enable.
// RL15: complex and simple modes: clock and enable pins are plain array inputs.
// RL16: sync one, arch one, io one: inner cells are combinational io.
// RL17: same settings: outer cells are combinational outputs without feedback.
// RL18: simple mode: each pin dedicated input or always-enabled combinational output.
// RL19: simple mode: outputs sum up to eight terms with per-cell polarity.
// RL20: simple mode: feedback goes through adjacent cell; centre cells have none.
// RL21: simple mode: the two centre cells cannot become inputs.
// RL22: simple is sync one, arch zero; io zero output, io one input.
// RL23: registered is sync zero, arch one; registers use pin enable, io term enable.
// RL24: registers capture term sum on shared clock rising edge, output through polarity.
module omc_output_macrocell (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input omc_pkg::omc_apb_req_type apbReq,
    output omc_pkg::omc_apb_rsp_type apbRsp,
    // product terms from the and array, eight per cell
    input omc_pkg::omc_terms_type termIn,
    // device pins
    input wire logic clkPin,
    input wire logic oePinN,
    input wire logic [7:0] pinIn,
    // pins out and feedback into the array
    output omc_pkg::omc_cell_out_type cellOut
);
    import omc_pkg::*;

    // ========================================
    // state
    omc_state_type st;
    omc_state_type next_st;
    omc_mode_type mode;
    logic modeValid;
    logic clkRise;

    // ========================================
    // per-cell views, bit i belongs to cell i
    logic [7:0] sumAllVec;
    logic [7:0] sumSevenVec;
    logic [7:0] oeTermVec;
    logic [7:0] outerMask;
    logic [7:0] centreMask;
    logic [7:0] regNext;
    logic [7:0] regValue;
    logic [7:0] regOeOn;
    logic [7:0] regFeedback;
    logic [7:0] cplxValue;
    logic [7:0] cplxOeOn;
    logic [7:0] cplxFeedback;
    logic [7:0] simpValue;
    logic [7:0] simpOeOn;
    logic [7:0] simpFeedback;
    logic [7:0] selValue;
    logic [7:0] selOeOn;
    logic [7:0] selFeedback;
    logic [7:0] selCellReg;
    logic [7:0] polOut;
    logic [7:0] driveOffN;

    // ========================================
    // register bus decode
    logic accessPhase;
    logic accessDone;
    logic writeDone;
    logic addrHit;
    logic hitMode;
    logic hitPolarity;
    logic hitIoSel;
    logic hitStatus;
    logic writeMode;
    logic writePolarity;
    logic writeIoSel;
    logic [31:0] readData;
    logic [31:0] statusWord;
    omc_apb_rsp_type rspNext;

    assign apbRsp = st.rsp;
    assign cellOut = st.cells;

    // ========================================
    // mode decode
    always_comb begin
        // an unlisted combination disables every output rather than guessing a mode
        case ({st.syncModeSelect, st.globalArchCtl}) // RL1 RL2
            2'b01: mode = OMC_REGISTERED; // RL23
            2'b11: mode = OMC_COMPLEX; // RL16
            2'b10: mode = OMC_SIMPLE; // RL22
            default: mode = OMC_INVALID;
        endcase
        modeValid = (mode != OMC_INVALID); // RL1
    end

    // ========================================
    // shared clock pin
    // the clock pin is sampled, so a register edge lags the pin by one cycle
    assign clkRise = clkPin & ~st.clkPinPrev; // RL24

    // ========================================
    // term sums and cell position
    always_comb begin
        sumAllVec = 8'h00;
        sumSevenVec = 8'h00;
        oeTermVec = 8'h00;
        outerMask = 8'h00;
        centreMask = 8'h00;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            // term 0 doubles as the enable term for registered-mode io cells and for every cell in complex mode
            sumAllVec[i] = |termIn[i]; // RL19
            sumSevenVec[i] = |termIn[i][`OMC_TERMS-1:1]; // RL10 RL14
            oeTermVec[i] = termIn[i][0]; // RL14
            outerMask[i] = (i == `OMC_OUTER_LOW) || (i == `OMC_OUTER_HIGH);
            centreMask[i] = (i == `OMC_CENTRE_LOW) || (i == `OMC_CENTRE_HIGH);
        end
    end

    // ========================================
    // registered mode: cell registers
    always_comb begin
        regNext = st.cellReg;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            // io cells keep their stored bit so a later mode change finds it intact
            if (clkRise && !st.cellIoSelect[i]) begin
                regNext[i] = sumAllVec[i]; // RL24 RL7 RL10
            end
        end
    end

    // ========================================
    // registered mode: outputs and feedback
    always_comb begin
        regValue = 8'h00;
        regOeOn = 8'h00;
        regFeedback = 8'h00;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            if (!st.cellIoSelect[i]) begin // RL4
                regValue[i] = regNext[i]; // RL8
                regOeOn[i] = ~oePinN; // RL6 RL7 RL23
                regFeedback[i] = regNext[i]; // RL8
            end else begin
                regValue[i] = sumSevenVec[i]; // RL10
                regOeOn[i] = oeTermVec[i]; // RL9 RL23
                regFeedback[i] = pinIn[i]; // RL6 RL8
            end
        end
    end

    // ========================================
    // complex mode view
    always_comb begin
        cplxValue = 8'h00;
        cplxOeOn = 8'h00;
        cplxFeedback = 8'h00;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            cplxValue[i] = sumSevenVec[i]; // RL14
            cplxOeOn[i] = oeTermVec[i]; // RL14 RL16
            if (outerMask[i]) begin
                // outer slots carry the dedicated pins instead of own pins
                if (i == `OMC_OUTER_LOW) begin
                    cplxFeedback[i] = clkPin; // RL11 RL13 RL15 RL17
                end else begin
                    cplxFeedback[i] = ~oePinN; // RL11 RL13 RL15 RL17
                end
            end else begin
                cplxFeedback[i] = pinIn[i]; // RL12 RL16
            end
        end
    end

    // ========================================
    // simple mode view
    always_comb begin
        simpValue = 8'h00;
        simpOeOn = 8'h00;
        simpFeedback = 8'h00;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            // the centre cells ignore their io bit and always drive
            if (centreMask[i] || !st.cellIoSelect[i]) begin
                simpValue[i] = sumAllVec[i]; // RL19 RL21
                simpOeOn[i] = 1'b1; // RL18 RL22
            end
            // outer slots carry the dedicated pins, the rest look at a neighbour
            if (i == `OMC_OUTER_LOW) begin
                simpFeedback[i] = clkPin; // RL15
            end else if (i == `OMC_OUTER_HIGH) begin
                simpFeedback[i] = ~oePinN; // RL15
            end else if (i <= `OMC_CENTRE_LOW) begin
                simpFeedback[i] = pinIn[i-1]; // RL20
            end else begin
                simpFeedback[i] = pinIn[i+1]; // RL20
            end
        end
    end

    // ========================================
    // mode select
    always_comb begin
        selValue = 8'h00;
        selOeOn = 8'h00;
        selFeedback = 8'h00;
        selCellReg = st.cellReg;
        case (mode)
            OMC_REGISTERED: begin
                selValue = regValue;
                selOeOn = regOeOn;
                selFeedback = regFeedback;
                selCellReg = regNext; // RL24
            end
            OMC_COMPLEX: begin
                selValue = cplxValue;
                selOeOn = cplxOeOn;
                selFeedback = cplxFeedback;
            end
            OMC_SIMPLE: begin
                selValue = simpValue;
                selOeOn = simpOeOn;
                selFeedback = simpFeedback;
            end
            default: begin
                // cell registers hold while no valid mode is set
                selCellReg = st.cellReg;
            end
        endcase
    end

    // ========================================
    // output stage: polarity and enable per cell
    always_comb begin
        polOut = 8'h00;
        driveOffN = 8'hFF;
        for (int i = 0; i < `OMC_CELLS; i++) begin
            if (st.polaritySelect[i]) begin
                polOut[i] = selValue[i]; // RL5
            end else begin
                polOut[i] = ~selValue[i]; // RL3 RL5
            end
            // enables are active low at the pad
            driveOffN[i] = ~selOeOn[i];
        end
    end

    // ========================================
    // register bus: address decode
    always_comb begin
        // whole-word compare, so an offset inside a word is unmapped
        hitMode = (apbReq.paddr == `OMC_ADDR_MODE);
        hitPolarity = (apbReq.paddr == `OMC_ADDR_POLARITY);
        hitIoSel = (apbReq.paddr == `OMC_ADDR_IOSEL);
        hitStatus = (apbReq.paddr == `OMC_ADDR_STATUS);
        addrHit = hitMode | hitPolarity | hitIoSel | hitStatus;
    end

    // ========================================
    // register bus: one wait state, writes land on the completing edge
    always_comb begin
        accessPhase = apbReq.psel & apbReq.penable;
        accessDone = accessPhase & st.rsp.pready;
        writeDone = accessDone & apbReq.pwrite;
        writeMode = writeDone & hitMode;
        writePolarity = writeDone & hitPolarity;
        writeIoSel = writeDone & hitIoSel;
    end

    // ========================================
    // status word, read only
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[`OMC_STATUS_VALID_BIT] = modeValid;
        statusWord[`OMC_STATUS_MODE_LSB +: 2] = mode;
        statusWord[`OMC_STATUS_CELLREG_LSB +: 8] = st.cellReg;
    end

    // ========================================
    // read data
    always_comb begin
        readData = 32'h0000_0000;
        if (hitMode) begin
            readData[`OMC_SYNC_BIT] = st.syncModeSelect;
            readData[`OMC_ARCH_BIT] = st.globalArchCtl;
        end else if (hitPolarity) begin
            readData[7:0] = st.polaritySelect;
        end else if (hitIoSel) begin
            readData[7:0] = st.cellIoSelect;
        end else if (hitStatus) begin
            readData = statusWord;
        end
    end

    // ========================================
    // bus response: each field stands for one cycle only
    always_comb begin
        rspNext.pready = accessPhase & ~st.rsp.pready;
        rspNext.prdata = 32'h0000_0000;
        rspNext.pslverr = 1'b0;
        if (rspNext.pready) begin
            rspNext.prdata = apbReq.pwrite ? 32'h0000_0000 : readData;
            rspNext.pslverr = ~addrHit;
        end
    end

    // ========================================
    // next state
    always_comb begin
        next_st = st;
        next_st.clkPinPrev = clkPin;

        // cells
        next_st.cellReg = selCellReg;
        next_st.cells.pinOut = polOut;
        next_st.cells.pinOutEnN = driveOffN;
        next_st.cells.feedback = selFeedback;

        // bus
        next_st.rsp = rspNext;

        // a write to status is dropped quietly, without an error
        if (writeMode) begin
            next_st.syncModeSelect = apbReq.pwdata[`OMC_SYNC_BIT]; // RL2
            next_st.globalArchCtl = apbReq.pwdata[`OMC_ARCH_BIT]; // RL2
        end
        if (writePolarity) begin
            next_st.polaritySelect = apbReq.pwdata[7:0]; // RL2
        end
        if (writeIoSel) begin
            next_st.cellIoSelect = apbReq.pwdata[7:0]; // RL2
        end
    end

    // ========================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.syncModeSelect <= `OMC_SYNC_RESET;
            st.globalArchCtl <= `OMC_ARCH_RESET;
            st.polaritySelect <= `OMC_POLARITY_RESET;
            st.cellIoSelect <= `OMC_IOSEL_RESET;
            st.cellReg <= `OMC_CELLREG_RESET;
            st.clkPinPrev <= 1'b0;
            st.cells.pinOut <= 8'h00;
            st.cells.pinOutEnN <= 8'hFF;
            st.cells.feedback <= 8'h00;
            st.rsp.pready <= 1'b0;
            st.rsp.prdata <= 32'h0000_0000;
            st.rsp.pslverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### testbench/omc_board_model.sv
`timescale 1ns/1ps
module omc_board_model (
    // pads from the device
    input omc_pkg::omc_cell_out_type cellOut,
    // board drive
    input wire logic [7:0] boardEn,
    input wire logic [7:0] boardVal,
    output logic [7:0] pinIn
);
    import omc_pkg::*;
    // device wins any pad it drives; undriven pads float high on the pull-ups
    assign pinIn = (~cellOut.pinOutEnN & cellOut.pinOut) | (cellOut.pinOutEnN & (~boardEn | boardVal));
endmodule

// ### testbench/omc_output_macrocell_assertions.sv
`timescale 1ns/1ps
module omc_output_macrocell_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input omc_pkg::omc_apb_req_type apbReq,
    input omc_pkg::omc_apb_rsp_type apbRsp,
    // array and pins
    input omc_pkg::omc_terms_type termIn,
    input wire logic clkPin,
    input wire logic oePinN,
    input wire logic [7:0] pinIn,
    input omc_pkg::omc_cell_out_type cellOut
);
    import omc_pkg::*;
    // ========================================
    // configuration shadow rebuilt from completed writes
    logic [17:0] cfg;
    logic [17:0] cfgOld;
    logic [7:0] orQ, or7Q, t0Q, pinQ;
    logic clkQ, oeQ;
    wire wr = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready;
    // outputs lag the config by an edge, so judge only once it has stood
    wire ok = cfg == cfgOld;
    wire [1:0] md = cfg[17:16];
    wire [7:0] pol = cfg[15:8];
    wire [7:0] io = cfg[7:0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
            cfgOld <= '0;
        end else begin
            cfgOld <= cfg;
            if (wr && apbReq.paddr == 12'h000) cfg[17:16] <= apbReq.pwdata[1:0];
            if (wr && apbReq.paddr == 12'h004) cfg[15:8] <= apbReq.pwdata[7:0];
            if (wr && apbReq.paddr == 12'h008) cfg[7:0] <= apbReq.pwdata[7:0];
        end
    end
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            orQ[i] <= |termIn[i];
            or7Q[i] <= |termIn[i][7:1];
            t0Q[i] <= termIn[i][0];
        end
        pinQ <= pinIn;
        clkQ <= clkPin;
        oeQ <= oePinN;
    end
    // ========================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_wait: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
        else $error("pready late");
    a_err_map: assert property (apbRsp.pready |-> apbRsp.pslverr == !(apbReq.paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("pslverr wrong");
    a_idle_off: assert property (ok && md == 2'b00 |-> cellOut.pinOutEnN == 8'hff && cellOut.feedback == 8'h00)
        else $error("invalid mode drives");
    a_simple_oe: assert property (ok && md == 2'b01 |-> cellOut.pinOutEnN == (io & 8'he7))
        else $error("simple enable wrong");
    a_simple_out: assert property (ok && md == 2'b01 |-> ((cellOut.pinOut ^ ~(orQ ^ pol)) & ~cellOut.pinOutEnN) == 8'h00)
        else $error("simple output wrong");
    a_simple_fb: assert property (ok && md == 2'b01 |-> cellOut.feedback == {!oeQ, pinQ[7:5], pinQ[2:0], clkQ})
        else $error("simple feedback wrong");
    a_complex_cell: assert property (ok && md == 2'b11 |-> cellOut.pinOutEnN == ~t0Q && cellOut.feedback == {!oeQ, pinQ[6:1], clkQ})
        else $error("complex cell wrong");
    a_reg_oe: assert property (ok && md == 2'b10 |-> cellOut.pinOutEnN == ((io & ~t0Q) | (~io & {8{oeQ}})))
        else $error("registered enable wrong");
    a_reg_io_out: assert property (ok && md == 2'b10 |-> ((cellOut.pinOut ^ ~(or7Q ^ pol)) & io) == 8'h00)
        else $error("io output wrong");
    a_reg_hold: assert property (ok && md == 2'b10 && !(clkPin && !clkQ) ##1 ok |-> $stable(cellOut.pinOut & ~io))
        else $error("register moved without clock");
endmodule
bind omc_output_macrocell omc_output_macrocell_assertions chk_u (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .termIn(termIn), .clkPin(clkPin), .oePinN(oePinN), .pinIn(pinIn), .cellOut(cellOut));

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import omc_pkg::*;
    typedef struct packed {
        logic [1:0] md;
        logic [7:0] pol, io;
        logic oeN;
        logic [7:0] enN, out, mask;
    } omc_row_type;
    logic clk, rst, clkPin, oePinN, er;
    logic [7:0] pinIn, boardEn, boardVal;
    logic [31:0] rd;
    omc_apb_req_type req;
    omc_apb_rsp_type rsp;
    omc_terms_type termIn;
    omc_cell_out_type cellOut;
    int err_count, total_checks;
    // terms give or8 eb, or7 ca, term0 a9
    omc_row_type rows [5] = '{'{2'b00, 8'h0f, 8'h00, 1'b1, 8'hff, 8'h00, 8'h00},
        '{2'b01, 8'h0f, 8'h3c, 1'b1, 8'h24, 8'h1b, 8'hdb}, '{2'b11, 8'h0f, 8'h00, 1'b1, 8'h56, 8'h3a, 8'ha9},
        '{2'b10, 8'h0f, 8'hff, 1'b1, 8'h56, 8'h3a, 8'ha9}, '{2'b10, 8'h0f, 8'h00, 1'b0, 8'h00, 8'hf0, 8'hff}};
    omc_output_macrocell dut_u (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .termIn(termIn), .clkPin(clkPin),
        .oePinN(oePinN), .pinIn(pinIn), .cellOut(cellOut));
    omc_board_model board_u (.cellOut(cellOut), .boardEn(boardEn), .boardVal(boardVal), .pinIn(pinIn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
        chk("pready", 32'h1, 32'(rsp.pready));
    endtask
    task automatic setc(input logic [1:0] m, input logic [7:0] p, input logic [7:0] i);
        apb(1'b1, 12'h000, 32'(m));
        apb(1'b1, 12'h004, 32'(p));
        apb(1'b1, 12'h008, 32'(i));
        wt(3);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ========================================
    // sequence
    initial begin
        #50000;
        err_count++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        termIn = 64'h8102_0100_0300_8001;
        {clkPin, oePinN, boardEn, boardVal, err_count, total_checks} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("mode reset", 32'h0, rd);
        foreach (rows[k]) begin
            oePinN <= rows[k].oeN;
            setc(rows[k].md, rows[k].pol, rows[k].io);
            chk("enables", 32'(rows[k].enN), 32'(cellOut.pinOutEnN));
            chk("drive", 32'(rows[k].out & rows[k].mask), 32'(cellOut.pinOut & rows[k].mask));
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("polarity", 32'h0f, rd);
        $display("table done");
        clkPin <= 1'b1;
        wt(3);
        chk("capture", 32'h1b, 32'(cellOut.pinOut));
        apb(1'b0, 12'h00c, 32'h0);
        chk("status", 32'h0000_eb01, rd);
        termIn <= '0;
        wt(3);
        chk("hold", 32'h1b, 32'(cellOut.pinOut));
        clkPin <= 1'b0;
        wt(2);
        clkPin <= 1'b1;
        wt(3);
        chk("recapture", 32'hf0, 32'(cellOut.pinOut));
        $display("register test done");
        termIn <= 64'h8102_0100_0300_8001;
        boardEn <= 8'he7;
        boardVal <= 8'ha5;
        setc(2'b01, 8'h0f, 8'he7);
        chk("centre enables", 32'he7, 32'(cellOut.pinOutEnN));
        chk("simple feedback", 32'hdb, 32'(cellOut.feedback));
        setc(2'b11, 8'h0f, 8'h00);
        chk("complex feedback", 32'hbd, 32'(cellOut.feedback));
        $display("feedback test done");
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
        rst <= 1'b1;
        wt(2);
        chk("reset enables", 32'hff, 32'(cellOut.pinOutEnN));
        rst <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        chk("io reset", 32'h0, rd);
        $display("reset test done");
        end_of_test();
    end
endmodule
